// ===== dv/cfc_bus_node.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// Other nodes on the bus, with free running bit timing
// ------------------------------------------------------------
module cfc_bus_node (
  input wire logic clock,
  input wire logic tx_start,
  output logic sample_point,
  output logic rx_bit,
  output logic rx_sof,
  output logic hdr_valid,
  output logic hdr_fdf,
  output logic hdr_res,
  output logic hdr_brs,
  output logic rx_done,
  output logic rx_match,
  output logic [1:0] rx_dest,
  output logic [28:0] rx_id,
  output logic [3:0] rx_dlc,
  output logic rx_rtr,
  output logic tx_done,
  output logic tx_ok
);
  logic [1:0] bit_cnt;
  logic tx_ok_next;
  int tx_wait;
  int tx_delay;
  initial begin
    {bit_cnt, sample_point, rx_sof, hdr_valid, rx_done, tx_done, tx_ok} = '0;
    {hdr_fdf, hdr_res, hdr_brs, rx_match, rx_rtr, rx_bit, tx_ok_next} = 7'h7f;
    {rx_dest, rx_id, rx_dlc} = '0;
    tx_wait = 0;
    tx_delay = 3;
  end
  always @(posedge clock) begin
    bit_cnt <= bit_cnt + 2'h1;
    sample_point <= (bit_cnt == 2'h3);
  end
  // Result line toggles while no transmission ends
  always @(posedge clock) begin
    tx_done <= 1'b0;
    tx_ok <= ~tx_ok;
    if (tx_start) begin
      tx_wait <= tx_delay;
    end else if (tx_wait == 1) begin
      tx_done <= 1'b1;
      tx_ok <= tx_ok_next;
      tx_wait <= 0;
    end else if (tx_wait > 1) begin
      tx_wait <= tx_wait - 1;
    end
  end
  task automatic frame_head(input logic fdf, input logic res, input logic brs);
    @(posedge clock);
    rx_sof <= 1'b1;
    rx_bit <= 1'b0;
    @(posedge clock);
    rx_sof <= 1'b0;
    hdr_valid <= 1'b1;
    {hdr_fdf, hdr_res, hdr_brs} <= {fdf, res, brs};
    @(posedge clock);
    hdr_valid <= 1'b0;
    {hdr_fdf, hdr_res, hdr_brs} <= ~{fdf, res, brs};
    rx_bit <= 1'b1;
  endtask
  task automatic frame_end(input logic [1:0] dest, input logic [28:0] id,
      input logic [3:0] dlc, input logic rtr, input logic match);
    @(posedge clock);
    rx_done <= 1'b1;
    {rx_dest, rx_id, rx_dlc, rx_rtr, rx_match} <= {dest, id, dlc, rtr, match};
    @(posedge clock);
    rx_done <= 1'b0;
    {rx_dest, rx_id, rx_dlc, rx_rtr, rx_match} <= ~{dest, id, dlc, rtr, match};
  endtask
endmodule

// ===== dv/tb_cfc_core.sv
`timescale 1ns/1ns
`define CHK(what, exp, got) begin n_checks++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("MISMATCH %s expected %0h seen %0h", what, exp, got); end end
module tb_cfc_core
  import cfc_pkg::*;
;
  logic clock, clk_en, rst_b, reg_wr, reg_rd, irq, seen;
  logic [ADDR_W-1:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd_val;
  logic sample_point, rx_bit, rx_sof, hdr_valid, hdr_fdf, hdr_res, hdr_brs;
  logic rx_done, rx_match, rx_rtr, tx_done, tx_ok, tx_start, tx_fd, tx_brs;
  logic [1:0] rx_dest, rx_store_dest, activity_state;
  logic [28:0] rx_id, rx_store_id;
  logic [3:0] rx_dlc, rx_store_dlc, tx_index;
  logic [6:0] rx_store_len;
  logic rx_store, rx_store_remote, brs_switch, error_frame, test_mode, bus_monitor_enable;
  int n_mismatch = 0;
  int n_checks = 0;
  cfc_core uut (.clock, .clk_en, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .irq, .sample_point, .rx_bit, .rx_sof, .hdr_valid, .hdr_fdf, .hdr_res, .hdr_brs, .rx_done,
    .rx_match, .rx_dest, .rx_id, .rx_dlc, .rx_rtr, .tx_done, .tx_ok, .tx_start, .tx_index,
    .tx_fd, .tx_brs, .rx_store, .rx_store_dest, .rx_store_id, .rx_store_dlc, .rx_store_len,
    .rx_store_remote, .brs_switch, .error_frame, .test_mode, .bus_monitor_enable,
    .activity_state);
  cfc_bus_node node (.clock, .tx_start, .sample_point, .rx_bit, .rx_sof, .hdr_valid,
    .hdr_fdf, .hdr_res, .hdr_brs, .rx_done, .rx_match, .rx_dest, .rx_id, .rx_dlc, .rx_rtr,
    .tx_done, .tx_ok);
  // ------------------------------------------------------------
  // Bus cycles and helpers
  // ------------------------------------------------------------
  initial clock = 1'b0;
  always #20 clock = ~clock;
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wait_act(input logic [1:0] v, input int lim);
    for (int i = 0; i < lim && activity_state !== v; i++) wait_cyc(1);
    `CHK("activity_state", v, activity_state)
  endtask
  task automatic wait_tx(input logic [3:0] idx);
    int i;
    i = 0;
    do begin
      wait_cyc(1);
      i++;
    end while (i < 20 && tx_start !== 1'b1);
    `CHK("tx_start", 1'b1, tx_start)
    `CHK("tx_index", idx, tx_index)
  endtask
  task automatic set_ctrl(input logic [31:0] v);
    wr(OFS_CORE_CTRL, 32'h01);
    wr(OFS_CORE_CTRL, 32'h03);
    wr(OFS_CORE_CTRL, v | 32'h03);
    wr(OFS_CORE_CTRL, v);
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_config();
    rd(OFS_TOUT_VAL);
    `CHK("timeout_count_value", 32'hffff, rd_val)
    wr(OFS_CORE_CTRL, 32'h03);
    wr(OFS_CORE_CTRL, 32'h1f);
    rd(OFS_CORE_CTRL);
    `CHK("core_control_register", 32'h1f, rd_val)
    `CHK("test_mode", 1'b1, test_mode)
    `CHK("bus_monitor_enable", 1'b1, bus_monitor_enable)
    wr(OFS_TX_ADD, 32'h01);
    wr(OFS_TOUT_CFG, 32'h00060001);
    rd(OFS_TX_PEND);
    `CHK("tx_pending", 32'h0, rd_val)
    rd(OFS_TOUT_VAL);
    `CHK("timeout_count_value", 32'h6, rd_val)
    wr(OFS_CORE_CTRL, 32'h09);
    wr(OFS_CORE_CTRL, 32'h11);
    rd(OFS_CORE_CTRL);
    `CHK("core_control_register", 32'h09, rd_val)
    wr(8'h40, 32'hffffffff);
    rd(8'h40);
    `CHK("unmapped", 32'h0, rd_val)
  endtask
  task automatic t_timeout();
    wr(OFS_IRQ_MASK, 32'h0);
    wait_cyc(30);
    rd(OFS_TOUT_VAL);
    `CHK("timeout_count_value", 32'h0, rd_val)
    `CHK("irq", 1'b0, irq)
    wr(OFS_IRQ_MASK, 32'h04);
    wait_cyc(2);
    `CHK("irq", 1'b1, irq)
    rd(OFS_IRQ_STAT);
    `CHK("irq_status", 32'h04, rd_val)
    wait_cyc(1);
    `CHK("irq", 1'b0, irq)
    wr(OFS_IRQ_MASK, 32'h1f);
    wr(OFS_TOUT_CFG, 32'h0);
  endtask
  task automatic t_tx();
    set_ctrl(32'h0);
    wait_cyc(30);
    `CHK("activity_state", ACT_SYNC, activity_state)
    wait_act(ACT_IDLE, 40);
    wr(OFS_TX_ADD, 32'h05);
    wait_tx(4'h0);
    `CHK("tx_fd", 1'b0, tx_fd)
    wait_tx(4'h2);
    wait_cyc(6);
    node.tx_ok_next = 1'b0;
    node.tx_delay = 6;
    wr(OFS_TX_ADD, 32'h02);
    wait_tx(4'h1);
    wait_tx(4'h1);
    wr(OFS_TX_CANCEL, 32'h02);
    node.tx_ok_next = 1'b1;
    wait_cyc(12);
    rd(OFS_TX_PEND);
    `CHK("tx_pending", 32'h0, rd_val)
    rd(OFS_IRQ_STAT);
    `CHK("irq_status", 32'h02, rd_val)
  endtask
  task automatic t_rx();
    for (int d = 0; d < 4; d++) begin
      node.frame_head(1'b0, 1'b0, 1'b0);
      node.frame_end(d[1:0], 29'h1abc000 + d, 4'ha, 1'b1, 1'b1);
      #1;
      `CHK("rx_store", d != 3, rx_store)
      if (d != 3) begin
        `CHK("rx_store_dest", d[1:0], rx_store_dest)
        `CHK("rx_store_id", 29'h1abc000 + d, rx_store_id)
        `CHK("rx_store_len", 7'h08, rx_store_len)
        `CHK("rx_store_remote", 1'b1, rx_store_remote)
      end
    end
    node.frame_head(1'b0, 1'b0, 1'b0);
    node.frame_end(2'h1, 29'h5, 4'h1, 1'b0, 1'b0);
    #1;
    `CHK("rx_store", 1'b0, rx_store)
    seen = 1'b0;
    for (int i = 0; i < 20; i++) begin
      wait_cyc(1);
      seen = seen | tx_start;
    end
    `CHK("tx_start", 1'b0, seen)
  endtask
  task automatic t_fd();
    rd(OFS_IRQ_STAT);
    node.frame_head(1'b1, 1'b0, 1'b0);
    #1;
    `CHK("error_frame", 1'b1, error_frame)
    node.frame_end(DEST_NONE, 29'h0, 4'h0, 1'b0, 1'b1);
    wait_act(ACT_IDLE, 100);
    rd(OFS_IRQ_STAT);
    `CHK("irq_status", 32'h10, rd_val)
    set_ctrl(32'hc0);
    wait_act(ACT_IDLE, 100);
    node.frame_head(1'b1, 1'b0, 1'b1);
    #1;
    `CHK("brs_switch", 1'b1, brs_switch)
    node.frame_end(2'h2, 29'h7ff, 4'hd, 1'b0, 1'b1);
    #1;
    `CHK("rx_store_len", 7'h20, rx_store_len)
    `CHK("rx_store_dlc", 4'hd, rx_store_dlc)
    rd(OFS_PROT_STAT);
    `CHK("last_fd_brs", 2'h3, rd_val[4:3])
    node.frame_head(1'b1, 1'b0, 1'b0);
    #1;
    `CHK("brs_switch", 1'b0, brs_switch)
    node.frame_end(DEST_NONE, 29'h0, 4'h0, 1'b0, 1'b1);
    wr(OFS_TX_ADD, 32'h08);
    wait_tx(4'h3);
    `CHK("tx_fd", 1'b1, tx_fd)
    `CHK("tx_brs", 1'b1, tx_brs)
    wait_cyc(12);
    rd(OFS_IRQ_STAT);
    node.frame_head(1'b1, 1'b1, 1'b0);
    #1;
    `CHK("error_frame", 1'b0, error_frame)
    wait_act(ACT_SYNC, 8);
    rd(OFS_IRQ_STAT);
    `CHK("irq_status", 32'h08, rd_val)
    set_ctrl(32'he0);
    wait_act(ACT_IDLE, 100);
    rd(OFS_PROT_STAT);
    `CHK("protocol_exception_event", 1'b1, rd_val[PS_PXE])
    node.frame_head(1'b1, 1'b1, 1'b0);
    #1;
    `CHK("error_frame", 1'b1, error_frame)
    rd(OFS_PROT_STAT);
    `CHK("protocol_exception_event", 1'b1, rd_val[PS_PXE])
  endtask
  task automatic end_of_test();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #400000;
    n_mismatch++;
    end_of_test();
  end
  initial begin
    rst_b = 1'b0;
    clk_en = 1'b1;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    t_config();
    t_timeout();
    t_tx();
    t_rx();
    t_fd();
    end_of_test();
  end
endmodule

// ===== hdl/cfc_core.sv
`timescale 1ns/1ns
module cfc_core
  import cfc_pkg::*;
#(
  parameter int TX_BUFS = 8
) (
  input wire logic clock,
  input wire logic clk_en,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq,
  input wire logic sample_point,
  input wire logic rx_bit,
  input wire logic rx_sof,
  input wire logic hdr_valid,
  input wire logic hdr_fdf,
  input wire logic hdr_res,
  input wire logic hdr_brs,
  input wire logic rx_done,
  input wire logic rx_match,
  input wire logic [1:0] rx_dest,
  input wire logic [28:0] rx_id,
  input wire logic [3:0] rx_dlc,
  input wire logic rx_rtr,
  input wire logic tx_done,
  input wire logic tx_ok,
  output logic tx_start,
  output logic [$clog2(TX_BUFS+1)-1:0] tx_index,
  output logic tx_fd,
  output logic tx_brs,
  output logic rx_store,
  output logic [1:0] rx_store_dest,
  output logic [28:0] rx_store_id,
  output logic [3:0] rx_store_dlc,
  output logic [6:0] rx_store_len,
  output logic rx_store_remote,
  output logic brs_switch,
  output logic error_frame,
  output logic test_mode,
  output logic bus_monitor_enable,
  output logic [1:0] activity_state
);
  localparam int IW = $clog2(TX_BUFS+1);

  if (TX_BUFS < 1 || TX_BUFS > 32) begin : g_bad_bufs
    $error("TX_BUFS must lie in 1..32");
  end

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [7:0] core_control_register;
  logic [4:0] protocol_status_register;
  logic [31:0] timeout_counter_config_register;
  logic [15:0] timeout_count_value;
  logic [TX_BUFS-1:0] tx_pend;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  cfc_act_t act;
  logic [3:0] sync_cnt;
  logic px_wait;
  logic fd_cur;
  logic [IW-1:0] tx_cur;

  // ------------------------------------------------------------
  // Register decode
  // ------------------------------------------------------------
  wire cce = core_control_register[CC_CCE];
  wire init = core_control_register[CC_INIT];
  wire cfg_ok = init & cce;
  wire fd_operation_enable = core_control_register[CC_FD_OPERATION_ENABLE];
  wire protocol_exception_handling_disable = core_control_register[CC_PROTOCOL_EXCEPTION_HANDLING_DISABLE];
  wire disable_auto_retransmit = core_control_register[CC_DAR];
  wire wr_cc = reg_wr & (reg_addr == OFS_CORE_CTRL);
  wire wr_tc = reg_wr & (reg_addr == OFS_TOUT_CFG);
  wire wr_add = reg_wr & (reg_addr == OFS_TX_ADD);
  wire wr_cancel = reg_wr & (reg_addr == OFS_TX_CANCEL);
  wire wr_mask = reg_wr & (reg_addr == OFS_IRQ_MASK);
  wire rd_ps = reg_rd & (reg_addr == OFS_PROT_STAT);
  wire rd_is = reg_rd & (reg_addr == OFS_IRQ_STAT);
  wire [7:0] wd = reg_wdata[7:0];

  // ------------------------------------------------------------
  // Core control write protection
  // ------------------------------------------------------------
  logic [7:0] cc_wr;
  assign cc_wr[CC_INIT] = wd[CC_INIT];
  assign cc_wr[CC_CCE] = init & wd[CC_INIT] & wd[CC_CCE];
  assign cc_wr[CC_MON] = cfg_ok ? wd[CC_MON]
                                : core_control_register[CC_MON] & wd[CC_MON];
  assign cc_wr[CC_TEST] = cfg_ok ? wd[CC_TEST]
                                 : core_control_register[CC_TEST] & wd[CC_TEST];
  assign cc_wr[CC_DAR] = cfg_ok ? wd[CC_DAR] : disable_auto_retransmit;
  assign cc_wr[CC_PROTOCOL_EXCEPTION_HANDLING_DISABLE] = cfg_ok ? wd[CC_PROTOCOL_EXCEPTION_HANDLING_DISABLE] : protocol_exception_handling_disable;
  assign cc_wr[CC_FD_OPERATION_ENABLE] = cfg_ok ? wd[CC_FD_OPERATION_ENABLE] : fd_operation_enable;
  assign cc_wr[CC_BRSE] = cfg_ok ? wd[CC_BRSE] : core_control_register[CC_BRSE];
  wire [7:0] next_cc = wr_cc ? cc_wr : core_control_register;

  // ------------------------------------------------------------
  // Frame header decode
  // ------------------------------------------------------------
  wire hdr_rx = hdr_valid & (act == ACT_RX);
  wire hdr_is_fd = hdr_rx & hdr_fdf;
  wire px_event = hdr_is_fd & fd_operation_enable & hdr_res;
  wire classic_err = hdr_is_fd & ~fd_operation_enable;
  wire form_err = px_event & protocol_exception_handling_disable;
  wire brs_hit = hdr_is_fd & fd_operation_enable & ~hdr_res & hdr_brs &
                 core_control_register[CC_BRSE];
  wire store_hit = rx_done & rx_match & (act == ACT_RX) & ~cce &
                   (rx_dest != DEST_NONE);
  wire tout_hit = ~cce & timeout_counter_config_register[TC_EN] & sample_point &
                  (timeout_count_value == 16'h0001);

  // ------------------------------------------------------------
  // Transmit selection
  // ------------------------------------------------------------
  logic [IW-1:0] tx_pick;
  always_comb begin
    tx_pick = '0;
    for (int i = TX_BUFS-1; i >= 0; i--) begin
      if (tx_pend[i]) begin
        tx_pick = IW'(i);
      end
    end
  end
  wire tx_go = (act == ACT_IDLE) & (|tx_pend) & ~cce & ~init & ~rx_sof &
               ~core_control_register[CC_MON];

  logic [TX_BUFS-1:0] done_mask;
  assign done_mask = (tx_done & (act == ACT_TX) & (tx_ok | disable_auto_retransmit)) ?
                     (TX_BUFS'(1) << tx_cur) : '0;
  logic [TX_BUFS-1:0] next_pend;
  assign next_pend = ((tx_pend & ~done_mask &
                       ~((wr_cancel & ~cce) ? reg_wdata[TX_BUFS-1:0] : '0)) |
                      ((wr_add & ~cce) ? reg_wdata[TX_BUFS-1:0] : '0));

  // ------------------------------------------------------------
  // Interrupts
  // ------------------------------------------------------------
  logic [IRQ_W-1:0] irq_set;
  assign irq_set[IRQ_RX] = store_hit;
  assign irq_set[IRQ_TX] = |done_mask;
  assign irq_set[IRQ_TOUT] = tout_hit;
  assign irq_set[IRQ_PXE] = px_event;
  assign irq_set[IRQ_PERR] = classic_err | form_err;
  wire [IRQ_W-1:0] next_irq_stat = (rd_is ? '0 : irq_stat) | irq_set;
  wire [IRQ_W-1:0] next_irq_mask = wr_mask ? reg_wdata[IRQ_W-1:0] : irq_mask;

  // ------------------------------------------------------------
  // Read mux
  // ------------------------------------------------------------
  logic [31:0] rd_mux;
  always_comb begin
    unique case (reg_addr)
      OFS_CORE_CTRL: rd_mux = {24'h0, core_control_register};
      OFS_PROT_STAT: rd_mux = {27'h0, protocol_status_register};
      OFS_TOUT_CFG: rd_mux = timeout_counter_config_register;
      OFS_TOUT_VAL: rd_mux = {16'h0, timeout_count_value};
      OFS_TX_PEND: rd_mux = 32'(tx_pend);
      OFS_IRQ_STAT: rd_mux = {27'h0, irq_stat};
      OFS_IRQ_MASK: rd_mux = {27'h0, irq_mask};
      default: rd_mux = 32'h0;
    endcase
  end

  // ------------------------------------------------------------
  // Payload length from dlc
  // ------------------------------------------------------------
  function automatic logic [6:0] dlc_len(input logic [3:0] d, input logic fd);
    logic [6:0] n;
    n = 7'h40;
    if (d <= DLC_CLASSIC_MAX) begin
      n = {3'h0, d};
    end else if (!fd) begin
      n = 7'h08;
    end else begin
      unique case (d)
        4'h9: n = 7'h0c;
        4'ha: n = 7'h10;
        4'hb: n = 7'h14;
        4'hc: n = 7'h18;
        4'hd: n = 7'h20;
        4'he: n = 7'h30;
        default: n = 7'h40;
      endcase
    end
    return n;
  endfunction

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      core_control_register <= CC_RESET;
      timeout_counter_config_register <= {TOP_RESET, 16'h0};
      tx_pend <= '0;
      irq_stat <= '0;
      irq_mask <= '0;
      irq <= 1'b0;
      reg_rdata <= 32'h0;
    end else if (clk_en) begin
      core_control_register <= next_cc;
      if (wr_tc) begin
        timeout_counter_config_register <= reg_wdata;
      end
      tx_pend <= next_pend;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      irq <= |(next_irq_stat & next_irq_mask);
      reg_rdata <= reg_rd ? rd_mux : 32'h0;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      timeout_count_value <= TOP_RESET;
    end else if (clk_en) begin
      if (cce) begin
        timeout_count_value <= timeout_counter_config_register[TC_TOP_LSB +: 16];
      end else if (timeout_counter_config_register[TC_EN] && sample_point &&
                   timeout_count_value != 16'h0) begin
        timeout_count_value <= timeout_count_value - 16'h0001;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      protocol_status_register <= '0;
    end else if (clk_en) begin
      protocol_status_register[1:0] <= act;
      protocol_status_register[PS_PXE] <= (protocol_status_register[PS_PXE] & ~rd_ps) |
                                          px_event;
      if (hdr_rx) begin
        protocol_status_register[PS_FD] <= hdr_fdf & fd_operation_enable;
        protocol_status_register[PS_BRS] <= brs_hit;
      end
    end
  end

  // ------------------------------------------------------------
  // Activity state machine
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      act <= ACT_SYNC;
      sync_cnt <= 4'h0;
      px_wait <= 1'b0;
      fd_cur <= 1'b0;
      tx_cur <= '0;
    end else if (clk_en) begin
      if (init) begin
        act <= ACT_SYNC;
        sync_cnt <= 4'h0;
        px_wait <= 1'b0;
      end else if (px_wait && sample_point) begin
        act <= ACT_SYNC;
        sync_cnt <= 4'h0;
        px_wait <= 1'b0;
      end else begin
        unique case (act)
          ACT_SYNC: begin
            if (sample_point) begin
              sync_cnt <= rx_bit ? sync_cnt + 4'h1 : 4'h0;
              if (rx_bit && sync_cnt == IDLE_BITS - 4'h1) begin
                act <= ACT_IDLE;
              end
            end
          end
          ACT_IDLE: begin
            if (rx_sof) begin
              act <= ACT_RX;
            end else if (tx_go) begin
              act <= ACT_TX;
              tx_cur <= tx_pick;
            end
          end
          ACT_RX: begin
            if (hdr_rx) begin
              fd_cur <= hdr_fdf & fd_operation_enable;
            end
            if (px_event && !protocol_exception_handling_disable) begin
              px_wait <= 1'b1;
            end
            if (rx_done) begin
              act <= ACT_IDLE;
            end
          end
          ACT_TX: begin
            if (tx_done) begin
              act <= ACT_IDLE;
            end
          end
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Outputs to the frame engine
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tx_start <= 1'b0;
      tx_index <= '0;
      tx_fd <= 1'b0;
      tx_brs <= 1'b0;
      rx_store <= 1'b0;
      rx_store_dest <= 2'h0;
      rx_store_id <= 29'h0;
      rx_store_dlc <= 4'h0;
      rx_store_len <= 7'h0;
      rx_store_remote <= 1'b0;
      brs_switch <= 1'b0;
      error_frame <= 1'b0;
      test_mode <= 1'b0;
      bus_monitor_enable <= 1'b0;
      activity_state <= 2'h0;
    end else if (clk_en) begin
      tx_start <= tx_go;
      if (tx_go) begin
        tx_index <= tx_pick;
        tx_fd <= fd_operation_enable;
        tx_brs <= fd_operation_enable & core_control_register[CC_BRSE];
      end
      rx_store <= store_hit;
      if (store_hit) begin
        rx_store_dest <= rx_dest;
        rx_store_id <= rx_id;
        rx_store_dlc <= rx_dlc;
        rx_store_len <= dlc_len(rx_dlc, fd_cur);
        rx_store_remote <= rx_rtr;
      end
      brs_switch <= brs_hit;
      error_frame <= classic_err | form_err;
      test_mode <= next_cc[CC_TEST];
      bus_monitor_enable <= next_cc[CC_MON];
      activity_state <= act;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  property p_toc_load;
    clk_en && cce |=> timeout_count_value == $past(timeout_counter_config_register[31:16]);
  endproperty
  a_toc_load: assert property (p_toc_load) else $error("timeout not preloaded");

  property p_hold_idle;
    clk_en && cce |=> !tx_start && !rx_store ##1 act == ACT_SYNC;
  endproperty
  a_hold_idle: assert property (p_hold_idle) else $error("handler left idle");

  property p_add_gate;
    clk_en && cce && (wr_add || wr_cancel) |=> tx_pend == $past(tx_pend);
  endproperty
  a_add_gate: assert property (p_add_gate) else $error("tx request taken");

  property p_test_set;
    clk_en && !cfg_ok && !core_control_register[CC_TEST] &&
      !core_control_register[CC_MON] |=> !core_control_register[CC_TEST] &&
      !core_control_register[CC_MON];
  endproperty
  a_test_set: assert property (p_test_set) else $error("test or monitor set");

  property p_dar;
    clk_en && !cfg_ok |=> $stable(disable_auto_retransmit);
  endproperty
  a_dar: assert property (p_dar) else $error("retransmit setting changed");

  property p_sync;
    act == ACT_SYNC ##1 act == ACT_IDLE |-> $past(sync_cnt) == IDLE_BITS - 4'h1;
  endproperty
  a_sync: assert property (p_sync) else $error("idle before integration");

  property p_store;
    clk_en && store_hit |=> rx_store && rx_store_id == $past(rx_id) &&
      rx_store_dest == $past(rx_dest);
  endproperty
  a_store: assert property (p_store) else $error("frame not stored");

  property p_no_reply;
    clk_en && (act != ACT_IDLE || tx_pend == '0) |=> !tx_start;
  endproperty
  a_no_reply: assert property (p_no_reply) else $error("unexpected tx start");

  property p_brs;
    clk_en && hdr_rx && hdr_fdf && fd_operation_enable && core_control_register[CC_BRSE] &&
      !hdr_res && hdr_brs |=> brs_switch;
  endproperty
  a_brs: assert property (p_brs) else $error("bit rate not switched");

  property p_pxe;
    clk_en && hdr_rx && hdr_fdf && hdr_res && fd_operation_enable |=> protocol_status_register[PS_PXE];
  endproperty
  a_pxe: assert property (p_pxe) else $error("exception not flagged");

  property p_px_integ;
    clk_en && px_wait && sample_point && !init |=> act == ACT_SYNC && !px_wait;
  endproperty
  a_px_integ: assert property (p_px_integ) else $error("no return to integrating");

  property p_err;
    clk_en && hdr_rx && hdr_fdf && (hdr_res && protocol_exception_handling_disable || !fd_operation_enable) |=> error_frame;
  endproperty
  a_err: assert property (p_err) else $error("error frame missing");

  c_tx: cover property (tx_start ##[1:50] act == ACT_IDLE);
  c_px: cover property (px_wait ##[1:20] act == ACT_SYNC);
  c_fd_store: cover property (rx_store && rx_store_len > 7'h08);
  c_brs: cover property (brs_switch);
endmodule

// ===== inc/cfc_pkg.sv
package cfc_pkg;
  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CORE_CTRL = 8'h00;
  localparam logic [7:0] OFS_PROT_STAT = 8'h04;
  localparam logic [7:0] OFS_TOUT_CFG = 8'h08;
  localparam logic [7:0] OFS_TOUT_VAL = 8'h0c;
  localparam logic [7:0] OFS_TX_ADD = 8'h10;
  localparam logic [7:0] OFS_TX_CANCEL = 8'h14;
  localparam logic [7:0] OFS_TX_PEND = 8'h18;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h1c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h20;
  // ------------------------------------------------------------
  // Core control fields
  // ------------------------------------------------------------
  localparam int CC_INIT = 0;
  localparam int CC_CCE = 1;
  localparam int CC_MON = 2;
  localparam int CC_DAR = 3;
  localparam int CC_TEST = 4;
  localparam int CC_PROTOCOL_EXCEPTION_HANDLING_DISABLE = 5;
  localparam int CC_FD_OPERATION_ENABLE = 6;
  localparam int CC_BRSE = 7;
  localparam logic [7:0] CC_RESET = 8'h01;
  // ------------------------------------------------------------
  // Protocol status and timeout fields
  // ------------------------------------------------------------
  localparam int PS_PXE = 2;
  localparam int PS_FD = 3;
  localparam int PS_BRS = 4;
  localparam int TC_EN = 0;
  localparam int TC_TOP_LSB = 16;
  localparam logic [15:0] TOP_RESET = 16'hffff;
  // ------------------------------------------------------------
  // Interrupt status fields
  // ------------------------------------------------------------
  localparam int IRQ_W = 5;
  localparam int IRQ_RX = 0;
  localparam int IRQ_TX = 1;
  localparam int IRQ_TOUT = 2;
  localparam int IRQ_PXE = 3;
  localparam int IRQ_PERR = 4;
  // ------------------------------------------------------------
  // Receive destinations and bus integration
  // ------------------------------------------------------------
  localparam logic [1:0] DEST_NONE = 2'h3;
  localparam logic [3:0] IDLE_BITS = 4'hb;
  localparam logic [3:0] DLC_CLASSIC_MAX = 4'h8;
  typedef enum logic [1:0] {
    ACT_SYNC = 2'h0,
    ACT_IDLE = 2'h1,
    ACT_RX = 2'h2,
    ACT_TX = 2'h3
  } cfc_act_t;
endpackage
